// ### rtl/pief_pkg.sv
// pief_pkg: offsets, bit positions, masks and reset values of the
// peripheral interrupt enable/flag pair.
// assumes: 8-bit register contents on a 32-bit apb, byte addressing.
package pief_pkg;

   localparam int          REG_ADDR_W         = 8;
   localparam int          REG_DATA_W         = 8;
   localparam int          APB_DATA_W         = 32;

   // byte addresses on apb
   localparam logic [7:0]  OFF_CONTROL        = 8'h08;
   localparam logic [7:0]  OFF_FLAGS          = 8'h0c;
   localparam logic [7:0]  OFF_FLAG_CLEAR     = 8'h10;
   localparam logic [7:0]  OFF_ENABLES        = 8'h8c;

   // source bit positions, shared by flags and enables
   localparam int          BIT_SLAVE_PORT     = 7;
   localparam int          BIT_CONVERTER      = 6;
   localparam int          BIT_SERIAL_RX      = 5;
   localparam int          BIT_SERIAL_TX      = 4;
   localparam int          BIT_UNUSED         = 3;
   localparam int          BIT_CAPTURE_CMP    = 2;
   localparam int          BIT_TIMER2_MATCH   = 1;
   localparam int          BIT_TIMER1_OVF     = 0;

   // main_irq_control bits
   localparam int          BIT_GLOBAL_EN      = 7;
   localparam int          BIT_GROUP_EN       = 6;

   localparam logic [7:0]  ENABLE_IMPL_MASK   = 8'hf7;
   localparam logic [7:0]  FLAG_IMPL_MASK     = 8'hf7;
   localparam logic [7:0]  FLAG_SW_WR_MASK    = 8'hc7;
   localparam logic [7:0]  CONTROL_IMPL_MASK  = 8'hc0;

   localparam logic [7:0]  FLAGS_RESET        = 8'h00;
   localparam logic [7:0]  ENABLES_RESET      = 8'h00;
   localparam logic [7:0]  CONTROL_RESET      = 8'h00;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b01,
      ST_ACCESS = 2'b10
   } pief_apb_state_e;

endpackage

// ### rtl/pief_reg_if.sv
// pief_reg_if: register access strobes between the apb port and the
// register pair.
// assumes: one clock domain; rdata/hit are combinational from the regs.
`timescale 1ns/1ps
interface pief_reg_if;
   import pief_pkg::*;

   logic [REG_ADDR_W-1:0] addr;
   logic                  wr;
   logic [REG_DATA_W-1:0] wdata;
   logic [REG_DATA_W-1:0] rdata;
   logic                  hit;

   modport port (output addr, output wr, output wdata, input rdata, input hit);
   modport regs (input addr, input wr, input wdata, output rdata, output hit);
endinterface

// ### rtl/pief_apb_port.sv
// pief_apb_port: apb slave handshake, one wait-free access phase.
// assumes: master keeps paddr/pwrite/pwdata stable through the access.
`timescale 1ns/1ps
module pief_apb_port
   import pief_pkg::*;
(
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  rstn,
   // apb
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [REG_ADDR_W-1:0] paddr,
   input  wire logic [APB_DATA_W-1:0] pwdata,
   output logic      [APB_DATA_W-1:0] prdata,
   output logic                       pready,
   output logic                       pslverr,
   // register side
   pief_reg_if.port                   bus
);

   pief_apb_state_e state_reg;

   assign bus.addr  = paddr;
   assign bus.wdata = pwdata[REG_DATA_W-1:0];
   // write lands only at the completing edge of the access phase
   assign bus.wr    = (state_reg == ST_ACCESS) && psel && penable && pwrite && bus.hit;

   // read data is captured at the setup edge so it stands still all access long
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         prdata    <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (psel && !penable) begin
                  state_reg <= ST_ACCESS;
                  pready    <= 1'b1;
                  pslverr   <= !bus.hit;
                  prdata    <= (bus.hit && !pwrite) ? {24'h000000, bus.rdata} : '0;
               end
            end
            ST_ACCESS: begin
               state_reg <= ST_IDLE;
               pready    <= 1'b0;
               pslverr   <= 1'b0;
               prdata    <= '0;
            end
            default: begin
               state_reg <= ST_IDLE;
               pready    <= 1'b0;
            end
         endcase
      end
   end

endmodule // pief_apb_port

// ### rtl/pief_irq_pair.sv
// pief_irq_pair: peripheral interrupt enable and flag registers with
// group and global gating onto one core interrupt request.
// assumes: periph_event comes from logic on the same clock, active high.
//
// Notes on behaviour
// - group enable off blocks every peripheral interrupt
// - enable register at 8ch, one bit per source
// - flag register at 0ch, same bit layout
// - events set flags regardless of any enable
// - enable bit 3 ignores writes, reads zero
// - all implemented bits zero after reset
// - set flags stay until software clears them
`timescale 1ns/1ps
module pief_irq_pair
   import pief_pkg::*;
(
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  rstn,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [REG_ADDR_W-1:0] paddr,
   input  wire logic [APB_DATA_W-1:0] pwdata,
   output logic      [APB_DATA_W-1:0] prdata,
   output logic                       pready,
   output logic                       pslverr,
   // peripheral events, one per source bit
   input  wire logic [REG_DATA_W-1:0] periph_event,
   // request to the core
   output logic                       core_irq
);

   pief_reg_if bus ();

   logic [REG_DATA_W-1:0] flag_reg;
   logic [REG_DATA_W-1:0] flag_next;
   logic [REG_DATA_W-1:0] enable_reg;
   logic [REG_DATA_W-1:0] control_reg;
   logic                  wr_flags;
   logic                  wr_clear;
   logic                  wr_enables;
   logic                  wr_control;
   logic                  irq_next;
   logic                  first_cycle_reg;

   pief_apb_port u_port (
      .clock   (clock),
      .rstn    (rstn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .bus     (bus.port)
   );

   // write decode
   always_comb begin
      wr_flags   = 1'b0;
      wr_clear   = 1'b0;
      wr_enables = 1'b0;
      wr_control = 1'b0;
      if (bus.addr == OFF_FLAGS) begin
         wr_flags   = bus.wr;
      end else if (bus.addr == OFF_FLAG_CLEAR) begin
         wr_clear   = bus.wr;
      end else if (bus.addr == OFF_ENABLES) begin
         wr_enables = bus.wr;
      end else if (bus.addr == OFF_CONTROL) begin
         wr_control = bus.wr;
      end
   end

   // read decode; the clear register is write-only and reads zero
   always_comb begin
      bus.rdata = '0;
      bus.hit   = 1'b0;
      if (bus.addr == OFF_FLAGS) begin
         bus.rdata = flag_reg;
         bus.hit   = 1'b1;
      end else if (bus.addr == OFF_ENABLES) begin
         bus.rdata = enable_reg;
         bus.hit   = 1'b1;
      end else if (bus.addr == OFF_CONTROL) begin
         bus.rdata = control_reg;
         bus.hit   = 1'b1;
      end else if (bus.addr == OFF_FLAG_CLEAR) begin
         bus.rdata = '0;
         bus.hit   = 1'b1;
      end
   end

   // per-bit flag update: the event is ored in last so a set in the same
   // cycle as a clear is never lost; the serial rx/tx flags are read-only
   // through the flag register and can only be dropped via the clear word
   for (genvar i = 0; i < REG_DATA_W; i++) begin : g_flag
      logic kept;
      always_comb begin
         kept = flag_reg[i];
         if (wr_flags && FLAG_SW_WR_MASK[i]) begin
            kept = bus.wdata[i];
         end
         if (wr_clear && bus.wdata[i]) begin
            kept = 1'b0;
         end
         flag_next[i] = FLAG_IMPL_MASK[i] & (kept | periph_event[i]);
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         flag_reg <= FLAGS_RESET;
      end else begin
         flag_reg <= flag_next;
      end
   end

   // unimplemented bit 3 is masked off on write so it always reads zero
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         enable_reg <= ENABLES_RESET;
      end else if (wr_enables) begin
         enable_reg <= bus.wdata & ENABLE_IMPL_MASK;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         control_reg <= CONTROL_RESET;
      end else if (wr_control) begin
         control_reg <= bus.wdata & CONTROL_IMPL_MASK;
      end
   end

   // registered request: one cycle behind the flags, but glitch free
   assign irq_next = (|(flag_reg & enable_reg))
                     && control_reg[BIT_GROUP_EN]
                     && control_reg[BIT_GLOBAL_EN];

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         core_irq <= 1'b0;
      end else begin
         core_irq <= irq_next;
      end
   end

   // helper for the reset check
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         first_cycle_reg <= 1'b1;
      end else begin
         first_cycle_reg <= 1'b0;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   property p_group_gate;
      !control_reg[BIT_GROUP_EN] |=> !core_irq;
   endproperty
   a_group_gate: assert property (p_group_gate)
      else $error("request raised with group enable off");

   property p_enable_write;
      wr_enables |=> enable_reg == ($past(bus.wdata) & ENABLE_IMPL_MASK);
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("enable register did not take written value");

   property p_enable_read;
      (psel && !penable && !pready && !pwrite && paddr == OFF_ENABLES)
         |=> pready && !pslverr && prdata == {24'h000000, $past(enable_reg)};
   endproperty
   a_enable_read: assert property (p_enable_read)
      else $error("enable register read mismatch");

   property p_flag_read;
      (psel && !penable && !pready && !pwrite && paddr == OFF_FLAGS)
         |=> pready && !pslverr && prdata == {24'h000000, $past(flag_reg)};
   endproperty
   a_flag_read: assert property (p_flag_read)
      else $error("flag register read mismatch");

   property p_event_sets;
      (periph_event != 8'h00) |=> (flag_reg & $past(periph_event) & FLAG_IMPL_MASK)
                   == ($past(periph_event) & FLAG_IMPL_MASK);
   endproperty
   a_event_sets: assert property (p_event_sets)
      else $error("event did not set its flag");

   property p_bit3_zero;
      !enable_reg[BIT_UNUSED] && !flag_reg[BIT_UNUSED];
   endproperty
   a_bit3_zero: assert property (p_bit3_zero)
      else $error("unimplemented bit 3 became set");

   property p_bit3_read;
      (psel && !penable && !pready && paddr == OFF_ENABLES) |=> !prdata[BIT_UNUSED];
   endproperty
   a_bit3_read: assert property (p_bit3_read)
      else $error("bit 3 read back as one");

   property p_reset_zero;
      first_cycle_reg |-> flag_reg == FLAGS_RESET && enable_reg == ENABLES_RESET;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("registers not zero after reset");

   property p_flag_sticky;
      (!wr_flags && !wr_clear) |=> (flag_reg & $past(flag_reg)) == $past(flag_reg);
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("flag dropped without software clear");

   property p_clear_works;
      wr_clear |=> (flag_reg & $past(bus.wdata) & ~$past(periph_event)) == 8'h00;
   endproperty
   a_clear_works: assert property (p_clear_works)
      else $error("write-one clear did not clear flag");

   property p_irq_raise;
      (|(flag_reg & enable_reg) && control_reg[BIT_GROUP_EN] && control_reg[BIT_GLOBAL_EN])
         |=> core_irq;
   endproperty
   a_irq_raise: assert property (p_irq_raise)
      else $error("request missing for enabled pending flag");

   property p_irq_drop;
      !(|(flag_reg & enable_reg)) |=> !core_irq;
   endproperty
   a_irq_drop: assert property (p_irq_drop)
      else $error("request without enabled pending flag");

   property p_unmapped;
      (psel && !penable && !pready && !bus.hit) |=> pslverr && pready;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped address not answered with error");

   property p_global_gate;
      !control_reg[BIT_GLOBAL_EN] |=> !core_irq;
   endproperty
   a_global_gate: assert property (p_global_gate)
      else $error("request raised with global enable off");

   property p_irq_gates;
      core_irq |-> $past(control_reg[BIT_GROUP_EN]) && $past(control_reg[BIT_GLOBAL_EN]);
   endproperty
   a_irq_gates: assert property (p_irq_gates)
      else $error("request without both gating bits set");

   property p_control_write;
      wr_control |=> control_reg == ($past(bus.wdata) & CONTROL_IMPL_MASK);
   endproperty
   a_control_write: assert property (p_control_write)
      else $error("control register did not take written value");

   property p_control_hold;
      !wr_control |=> $stable(control_reg);
   endproperty
   a_control_hold: assert property (p_control_hold)
      else $error("control register changed without a write");

   property p_enable_hold;
      !wr_enables |=> $stable(enable_reg);
   endproperty
   a_enable_hold: assert property (p_enable_hold)
      else $error("enable register changed without a write");

   property p_write_late;
      (psel && !penable && !pready && pwrite && paddr == OFF_ENABLES)
         |=> $stable(enable_reg);
   endproperty
   a_write_late: assert property (p_write_late)
      else $error("enable write landed in the setup cycle");

   property p_flag_sw_write;
      wr_flags |=> (flag_reg & FLAG_SW_WR_MASK)
         == (($past(bus.wdata) | $past(periph_event)) & FLAG_SW_WR_MASK);
   endproperty
   a_flag_sw_write: assert property (p_flag_sw_write)
      else $error("writable flags did not take written value");

   property p_flag_ro_kept;
      wr_flags |=> (flag_reg & ~FLAG_SW_WR_MASK & FLAG_IMPL_MASK)
         == (($past(flag_reg) | $past(periph_event)) & ~FLAG_SW_WR_MASK & FLAG_IMPL_MASK);
   endproperty
   a_flag_ro_kept: assert property (p_flag_ro_kept)
      else $error("read-only flag changed by a flag write");

   property p_no_spurious_set;
      !wr_flags |=> (flag_reg & ~$past(flag_reg) & ~$past(periph_event)) == 8'h00;
   endproperty
   a_no_spurious_set: assert property (p_no_spurious_set)
      else $error("flag set without an event or a write");

   property p_set_wins;
      (wr_clear && (|(bus.wdata & periph_event & FLAG_IMPL_MASK)))
         |=> (flag_reg & $past(bus.wdata & periph_event))
             == $past(bus.wdata & periph_event & FLAG_IMPL_MASK);
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("clear beat an event in the same cycle");

   property p_clear_read;
      (psel && !penable && !pready && !pwrite && paddr == OFF_FLAG_CLEAR)
         |=> pready && !pslverr && prdata == 32'h0000_0000;
   endproperty
   a_clear_read: assert property (p_clear_read)
      else $error("clear word did not read zero");

   property p_unmapped_write;
      (psel && penable && pready && pwrite && !bus.hit)
         |=> $stable(enable_reg) && $stable(control_reg);
   endproperty
   a_unmapped_write: assert property (p_unmapped_write)
      else $error("unmapped write changed a register");

   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready stood longer than one cycle");

   property p_idle_quiet;
      !pready |-> prdata == 32'h0000_0000 && !pslverr;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("read data or error outside the access cycle");

   property p_upper_zero;
      pready |-> prdata[APB_DATA_W-1:REG_DATA_W] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("upper read data bits not zero");

   c_irq_raised: cover property ($rose(core_irq));
   c_set_vs_clear: cover property (wr_clear && (|(bus.wdata & periph_event)));
   c_flag_write: cover property (wr_flags);
   c_unmapped: cover property (pslverr);

endmodule // pief_irq_pair

// ### testbench/pief_event_src.sv
// pief_event_src: stand-in for the on-chip peripherals that raise events.
// assumes: same clock as the block; one request gives a one-cycle pulse.
`timescale 1ns/1ps
module pief_event_src
   import pief_pkg::*;
(
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  rstn,
   // request from the bench
   input  wire logic                  fire,
   input  wire logic [REG_DATA_W-1:0] fire_mask,
   // events to the block
   output logic      [REG_DATA_W-1:0] periph_event
);
   // pulses, not levels: a level would hide a flag that fails to latch
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         periph_event <= '0;
      end else begin
         periph_event <= fire ? fire_mask : '0;
      end
   end
endmodule // pief_event_src

// ### testbench/pief_irq_pair_tb.sv
// pief_irq_pair_tb: self-checking bench for the enable/flag pair.
// assumes: apb slave answers after one access cycle; event source model.
`timescale 1ns/1ps
module pief_irq_pair_tb;
   import pief_pkg::*;
   logic        clock, rstn, psel, penable, pwrite, pready, pslverr;
   logic        core_irq, fire, err;
   logic [7:0]  paddr, fire_mask, periph_event;
   logic [31:0] pwdata, prdata, rd;
   int          mismatches, checked, cycles;

   pief_irq_pair u_dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .periph_event(periph_event), .core_irq(core_irq));
   pief_event_src u_src (.clock(clock), .rstn(rstn), .fire(fire), .fire_mask(fire_mask),
      .periph_event(periph_event));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // whole run is about 130 cycles; the ceiling leaves ample margin
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         $display("wrong value at %0t: run did not finish", $time);
         close_out();
      end
   end

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %b want %b", $time, what, got, exp);
      end
   endtask

   // one apb transfer; entered just after a rising edge, returns one idle edge after the completing edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1);
      chk_val(n, 1, "access cycles");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so the next call never reassigns psel in this step
      @(posedge clock);
   endtask

   task automatic pulse(input logic [7:0] m);
      fire <= 1'b1;
      fire_mask <= m;
      @(posedge clock);
      fire <= 1'b0;
      repeat (3) @(posedge clock);
   endtask

   task automatic irq_is(input logic exp);
      repeat (3) @(posedge clock);
      chk_bit(core_irq, exp, "core_irq");
   endtask

   task automatic t_reset;
      apb(1'b0, OFF_FLAGS, 32'h0);
      chk_val(rd, 32'h0000_0000, "flags after reset");
      apb(1'b0, OFF_ENABLES, 32'h0);
      chk_val(rd, 32'h0000_0000, "enables after reset");
      chk_bit(core_irq, 1'b0, "irq after reset");
      $display("test reset done");
   endtask

   task automatic t_enables;
      apb(1'b1, OFF_ENABLES, 32'h0000_00ff);
      apb(1'b0, OFF_ENABLES, 32'h0);
      chk_val(rd, 32'h0000_00f7, "enables all ones");
      apb(1'b1, OFF_ENABLES, 32'h0000_0008);
      apb(1'b0, OFF_ENABLES, 32'h0);
      chk_val(rd, 32'h0000_0000, "enable bit 3 alone");
      chk_bit(err, 1'b0, "enables error");
      $display("test enables done");
   endtask

   task automatic t_flags;
      pulse(8'hff);
      apb(1'b0, OFF_FLAGS, 32'h0);
      chk_val(rd, 32'h0000_00f7, "flags set, enables off");
      repeat (6) @(posedge clock);
      apb(1'b0, OFF_FLAGS, 32'h0);
      chk_val(rd, 32'h0000_00f7, "flags still held");
      chk_bit(core_irq, 1'b0, "no irq while disabled");
      apb(1'b1, OFF_FLAGS, 32'h0);
      apb(1'b0, OFF_FLAGS, 32'h0);
      chk_val(rd, 32'h0000_0030, "flags after zero write");
      // stale flags go before any enable is set
      apb(1'b1, OFF_FLAG_CLEAR, 32'h0000_00ff);
      apb(1'b0, OFF_FLAGS, 32'h0);
      chk_val(rd, 32'h0000_0000, "flags after clear");
      $display("test flags done");
   endtask

   task automatic t_gating;
      apb(1'b1, OFF_ENABLES, 32'h0000_0002);
      apb(1'b1, OFF_CONTROL, 32'h0000_00c0);
      pulse(8'h01);
      irq_is(1'b0);
      apb(1'b1, OFF_ENABLES, 32'h0000_0001);
      irq_is(1'b1);
      apb(1'b1, OFF_CONTROL, 32'h0000_0080);
      irq_is(1'b0);
      apb(1'b1, OFF_CONTROL, 32'h0000_0040);
      irq_is(1'b0);
      apb(1'b1, OFF_CONTROL, 32'h0000_00c0);
      irq_is(1'b1);
      apb(1'b1, OFF_FLAG_CLEAR, 32'h0000_0001);
      irq_is(1'b0);
      $display("test gating done");
   endtask

   task automatic t_unmapped;
      apb(1'b1, 8'h20, 32'h0000_00ff);
      chk_bit(err, 1'b1, "unmapped write error");
      apb(1'b0, 8'h20, 32'h0);
      chk_bit(err, 1'b1, "unmapped read error");
      chk_val(rd, 32'h0000_0000, "unmapped read data");
      apb(1'b0, OFF_ENABLES, 32'h0);
      chk_val(rd, 32'h0000_0001, "enables untouched");
      $display("test unmapped done");
   endtask

   // an event and its clear land on the same edge: the event must win
   task automatic t_set_wins;
      fire <= 1'b1;
      fire_mask <= 8'h04;
      fork
         apb(1'b1, OFF_FLAG_CLEAR, 32'h0000_0004);
         begin
            @(posedge clock);
            fire <= 1'b0;
         end
      join
      apb(1'b0, OFF_FLAGS, 32'h0);
      chk_val(rd, 32'h0000_0004, "event beats clear");
      apb(1'b0, OFF_FLAG_CLEAR, 32'h0);
      chk_val(rd, 32'h0000_0000, "clear word reads zero");
      apb(1'b1, OFF_FLAG_CLEAR, 32'h0000_0004);
      apb(1'b0, OFF_FLAGS, 32'h0);
      chk_val(rd, 32'h0000_0000, "flag after clear alone");
      $display("test set wins done");
   endtask

   task automatic t_reset_again;
      pulse(8'h81);
      chk_bit(core_irq, 1'b1, "irq before second reset");
      rstn <= 1'b0;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      apb(1'b0, OFF_FLAGS, 32'h0);
      chk_val(rd, 32'h0000_0000, "flags after second reset");
      apb(1'b0, OFF_ENABLES, 32'h0);
      chk_val(rd, 32'h0000_0000, "enables after second reset");
      chk_bit(core_irq, 1'b0, "irq after second reset");
      $display("test second reset done");
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fire = 1'b0;
      fire_mask = 8'h00;
      mismatches = 0;
      checked = 0;
      cycles = 0;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      t_reset();
      t_enables();
      t_flags();
      t_gating();
      t_unmapped();
      t_set_wins();
      t_reset_again();
      close_out();
   end
endmodule // pief_irq_pair_tb
